// file: core/det_pkg.sv
// Shared constants and types of the detector call conditioning block.
// Assumes a 100 MHz system clock and 32-bit classic Wishbone registers.
package det_pkg;

    // ====
    // Clock and time base
    localparam int CLK_NS       = 10;
    localparam int TICK_MS      = 100;
    localparam int TICK_CYC     = TICK_MS * 1_000_000 / CLK_NS;
    localparam int FRAME_RATE   = 30;
    localparam int FRAME_CYC    = 1_000_000_000 / (CLK_NS * FRAME_RATE);
    localparam int REFRESH_MS   = 1000;
    localparam int REFRESH_CYC  = REFRESH_MS * 1_000_000 / CLK_NS;
    localparam int LATENCY_MS   = 112;
    localparam int LATENCY_CYC  = LATENCY_MS * 1_000_000 / CLK_NS;
    localparam logic [7:0] PULSE_TICKS = 8'h02;

    // ====
    // Register map (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] CFG_BASE = 8'h10;

    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_GDIS_BIT  = 1;
    localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0003;

    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_FUNC_LSB = 4;
    localparam int CFG_DLY_LSB  = 8;
    localparam int CFG_EXT_LSB  = 16;
    localparam int CFG_ZONE_LSB = 24;
    localparam logic [31:0] CFG_MASK  = 32'h07FF_FF37;
    localparam logic [31:0] CFG_RST   = 32'h0000_0000;

    // ====
    // Modes
    typedef enum logic [2:0] {TM_OFF, TM_FULL_DLY, TM_NORM_DLY, TM_EXTEND, TM_DLY_EXT}
        timing_mode_t;
    typedef enum logic [1:0] {ZF_PRES, ZF_DIR_PRES, ZF_PULSE, ZF_DIR_PULSE} zone_func_t;

endpackage : det_pkg

// file: core/call_chan.sv
// One detection output: zone function then delay/extend timing.
// Assumes tick_i is a one-cycle pulse and inputs share clk_i.
`timescale 1ns/1ns
module call_chan #(
    parameter int CNT_W = 8
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic                  tick_i,
    input  wire logic                  occ_i,
    input  wire logic                  dir_ok_i,
    input  wire logic                  green_i,
    input  wire logic                  gate_dis_i,
    input  wire logic                  fail_i,
    input  wire det_pkg::timing_mode_t mode_i,
    input  wire det_pkg::zone_func_t   func_i,
    input  wire logic [CNT_W-1:0]      delay_i,
    input  wire logic [CNT_W-1:0]      extend_i,
    output logic                       call_o
);
    import det_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CALL, ST_EXTEND} chan_state_t;

    chan_state_t      state_ff;
    chan_state_t      nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [CNT_W-1:0] pulse_ff;
    logic             qual_ff;
    logic             call_ff;

    // ====
    // Zone function
    // four zone functions
    wire dir_sel   = (func_i == ZF_DIR_PRES) || (func_i == ZF_DIR_PULSE);
    wire pulse_sel = (func_i == ZF_PULSE) || (func_i == ZF_DIR_PULSE);
    wire qual      = occ_i && (!dir_sel || dir_ok_i);
    wire entry     = qual && !qual_ff;
    wire det       = pulse_sel ? (pulse_ff != '0) : qual;

    // ====
    // Timing selection
    // full-time delay runs always
    wire use_dly = (mode_i == TM_FULL_DLY) || (mode_i == TM_NORM_DLY) || (mode_i == TM_DLY_EXT);
    wire use_ext = (mode_i == TM_EXTEND) || (mode_i == TM_DLY_EXT);
    wire hold    = (mode_i == TM_NORM_DLY) && green_i && !gate_dis_i;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            ST_IDLE:
            begin
                // a new call waits out delay only in the delay modes
                if (det && use_dly)
                begin
                    nxt_state = ST_DELAY;
                    nxt_cnt   = delay_i;
                end
                else if (det)
                    nxt_state = ST_CALL;
            end
            ST_DELAY:
            begin
                if (!det)
                    nxt_state = ST_IDLE;
                else if (cnt_ff == '0)
                    nxt_state = ST_CALL;
                else if (tick_i && !hold)
                    nxt_cnt = cnt_ff - 1'b1;
            end
            ST_CALL:
            begin
                if (!det && use_ext)
                begin
                    nxt_state = ST_EXTEND;
                    nxt_cnt   = extend_i;
                end
                else if (!det)
                    nxt_state = ST_IDLE;
            end
            ST_EXTEND:
            begin
                if (det)
                    nxt_state = ST_CALL;
                else if (cnt_ff == '0)
                    nxt_state = ST_IDLE;
                else if (tick_i)
                    nxt_cnt = cnt_ff - 1'b1;
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_ff <= ST_IDLE;
            cnt_ff   <= '0;
            pulse_ff <= '0;
            qual_ff  <= 1'b0;
            call_ff  <= 1'b0;
        end
        else if (ce_i)
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            qual_ff  <= qual;
            if (entry)
                pulse_ff <= CNT_W'(PULSE_TICKS);
            else if (tick_i && pulse_ff != '0)
                pulse_ff <= pulse_ff - 1'b1;
            call_ff  <= fail_i || (nxt_state == ST_CALL) || (nxt_state == ST_EXTEND);
        end
    end

    assign call_o = call_ff;

endmodule : call_chan

// file: core/detector_call_delay_extend.sv
// Detector call conditioning: zone occupancy in, controller calls out.
// Assumes occupancy, direction and frame strobes come from clk_i logic;
// phase greens and fail flags are asynchronous pins.
`timescale 1ns/1ns
module detector_call_delay_extend #(
    parameter int NUM_OUT     = 8,
    parameter int NUM_ZONE    = 8,
    parameter int TICK_CYC    = det_pkg::TICK_CYC,
    parameter int FRAME_CYC   = det_pkg::FRAME_CYC,
    parameter int REFRESH_CYC = det_pkg::REFRESH_CYC
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic                frame_i,
    input  wire logic [NUM_ZONE-1:0] zone_occ_i,
    input  wire logic [NUM_ZONE-1:0] zone_dir_i,
    input  wire logic [NUM_OUT-1:0]  phase_green_i,
    input  wire logic                cam_fail_i,
    input  wire logic                power_fail_i,
    output logic      [NUM_OUT-1:0]  call_o,
    output logic      [NUM_ZONE-1:0] zone_hilite_o,
    output logic                     remote_frame_o
);
    import det_pkg::*;

    localparam int SYNC_W  = NUM_OUT + 2;
    localparam int TICK_W  = $clog2(TICK_CYC + 1);
    localparam int GAP_W   = $clog2(FRAME_CYC + 2);
    localparam int REF_W   = $clog2(REFRESH_CYC + 1);
    localparam int ZSEL_W  = $clog2(NUM_ZONE);

    // ====
    // Pin synchronisers
    logic [SYNC_W-1:0] meta_ff;
    logic [SYNC_W-1:0] sync_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else if (ce_i)
        begin
            meta_ff <= {power_fail_i, cam_fail_i, phase_green_i};
            sync_ff <= meta_ff;
        end
    end

    wire [NUM_OUT-1:0] green_s    = sync_ff[NUM_OUT-1:0];
    wire               cam_fail_s = sync_ff[NUM_OUT];
    wire               pwr_fail_s = sync_ff[NUM_OUT+1];

    // ====
    // Register bus decode
    logic [31:0] ctrl_ff;
    logic [31:0] cfg_ff [NUM_OUT];
    logic        ack_ff;
    logic [31:0] dat_ff;

    wire         access   = wb_cyc_i && wb_stb_i && !ack_ff;
    wire         wr       = access && wb_we_i;
    wire         hit_ctrl = (wb_adr_i == CTRL_OFS);
    wire         hit_stat = (wb_adr_i == STAT_OFS);
    wire [7:0]   cfg_off  = wb_adr_i - CFG_BASE;
    wire [5:0]   cfg_idx  = cfg_off[7:2];
    wire         hit_cfg  = (wb_adr_i >= CFG_BASE) && (wb_adr_i[1:0] == 2'b00)
                            && (int'(cfg_idx) < NUM_OUT);
    wire [31:0]  lane_msk = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] lanes,
                                          input logic [31:0] keep);
        merge = ((old_v & ~lanes) | (new_v & lanes)) & keep;
    endfunction : merge

    // ====
    // Control register
    wire enable   = ctrl_ff[CTRL_EN_BIT];
    wire gate_dis = ctrl_ff[CTRL_GDIS_BIT];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_ff <= CTRL_RST;
        else if (ce_i && wr && hit_ctrl)
            ctrl_ff <= merge(ctrl_ff, wb_dat_i, lane_msk, CTRL_MASK);
    end

    // ====
    // Per-output configuration
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++)
        begin : g_cfg
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    cfg_ff[g] <= CFG_RST | (32'(g % NUM_ZONE) << CFG_ZONE_LSB);
                else if (ce_i && wr && hit_cfg && int'(cfg_idx) == g)
                    cfg_ff[g] <= merge(cfg_ff[g], wb_dat_i, lane_msk, CFG_MASK);
            end
        end
    endgenerate

    // ====
    // Time base
    logic [TICK_W-1:0] tick_cnt_ff;
    logic              tick_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tick_cnt_ff <= '0;
            tick_ff     <= 1'b0;
        end
        else if (ce_i)
        begin
            tick_ff <= (tick_cnt_ff == TICK_W'(TICK_CYC - 1));
            if (tick_cnt_ff == TICK_W'(TICK_CYC - 1))
                tick_cnt_ff <= '0;
            else
                tick_cnt_ff <= tick_cnt_ff + 1'b1;
        end
    end

    // ====
    // Frame capture and frame-rate watchdog
    logic [NUM_ZONE-1:0] occ_ff;
    logic [NUM_ZONE-1:0] dir_ff;
    logic [GAP_W-1:0]    gap_ff;
    logic                frame_lost_ff;

    // A late frame is treated like a camera fault, so calls fail safe.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            occ_ff        <= '0;
            dir_ff        <= '0;
            gap_ff        <= '0;
            frame_lost_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            if (frame_i)
            begin
                occ_ff        <= zone_occ_i;
                dir_ff        <= zone_dir_i;
                gap_ff        <= '0;
                frame_lost_ff <= 1'b0;
            end
            else if (gap_ff == GAP_W'(FRAME_CYC))
                frame_lost_ff <= 1'b1;
            else
                gap_ff <= gap_ff + 1'b1;
        end
    end

    // ====
    // Monitor outputs
    logic [NUM_ZONE-1:0] hilite_ff;
    logic [REF_W-1:0]    ref_cnt_ff;
    logic                ref_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hilite_ff  <= '0;
            ref_cnt_ff <= '0;
            ref_ff     <= 1'b0;
        end
        else if (ce_i)
        begin
            hilite_ff <= occ_ff;
            ref_ff    <= (ref_cnt_ff == REF_W'(REFRESH_CYC - 1));
            if (ref_cnt_ff == REF_W'(REFRESH_CYC - 1))
                ref_cnt_ff <= '0;
            else
                ref_cnt_ff <= ref_cnt_ff + 1'b1;
        end
    end

    assign zone_hilite_o  = hilite_ff;
    assign remote_frame_o = ref_ff;

    // ====
    // Call channels
    // any failure forces calls
    wire fail_all = cam_fail_s || pwr_fail_s || frame_lost_ff || !enable;

    logic [NUM_OUT-1:0] call_w;

    generate
        for (g = 0; g < NUM_OUT; g++)
        begin : g_chan
            wire [ZSEL_W-1:0] zsel = cfg_ff[g][CFG_ZONE_LSB +: ZSEL_W];

            call_chan #(
                .CNT_W (8)
            ) u_chan (
                .clk_i      (clk_i),
                .rst_i      (rst_i),
                .ce_i       (ce_i),
                .tick_i     (tick_ff),
                .occ_i      (occ_ff[zsel]),
                .dir_ok_i   (dir_ff[zsel]),
                .green_i    (green_s[g]),
                .gate_dis_i (gate_dis),
                .fail_i     (fail_all),
                .mode_i     (timing_mode_t'(cfg_ff[g][CFG_MODE_LSB +: 3])),
                .func_i     (zone_func_t'(cfg_ff[g][CFG_FUNC_LSB +: 2])),
                .delay_i    (cfg_ff[g][CFG_DLY_LSB +: 8]),
                .extend_i   (cfg_ff[g][CFG_EXT_LSB +: 8]),
                .call_o     (call_w[g])
            );
        end
    endgenerate

    assign call_o = call_w;

    // ====
    // Status and read data
    wire [31:0] status = 32'({frame_lost_ff, pwr_fail_s, cam_fail_s, occ_ff, call_w});

    wire [31:0] rd_data = hit_ctrl ? ctrl_ff :
                          hit_stat ? status :
                          hit_cfg  ? cfg_ff[cfg_idx[$clog2(NUM_OUT)-1:0]] :
                          32'h0000_0000;

    // Unmapped addresses still ack: reads give zero, writes are dropped.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            dat_ff <= '0;
        end
        else if (ce_i)
        begin
            ack_ff <= access;
            if (access && !wb_we_i)
                dat_ff <= rd_data;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

endmodule : detector_call_delay_extend

// file: tb/ctl_model.sv
// Signal controller stand-in: drives phase greens, counts rises of call 0 only.
// Assumes it shares clk_i with the bench; greens change after an edge.
`timescale 1ns/1ns
module ctl_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] call_i,
    input  wire logic [7:0] green_req_i,
    output logic      [7:0] phase_green_o,
    output logic      [7:0] rise_cnt_o
);
    logic call0_ff;
    // ====
    // Greens and call edge count; a pulse and a held call both count once
    always_ff @(posedge clk_i)
    begin
        phase_green_o <= green_req_i;
        call0_ff      <= call_i[0];
        if (rst_i)
            rise_cnt_o <= 8'h00;
        else if (call_i[0] && !call0_ff)
            rise_cnt_o <= rise_cnt_o + 8'h01;
    end
endmodule : ctl_model

// file: tb/det_call_props.sv
// Port-level checks of the call conditioning block.
// Assumes it is bound into the top module and ce_i stays high.
`timescale 1ns/1ns
module det_call_props #(
    parameter int NUM_OUT     = 8,
    parameter int NUM_ZONE    = 8,
    parameter int FRAME_CYC   = 50,
    parameter int REFRESH_CYC = 16
) (
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                ce_i,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_ack_o,
    input wire logic                frame_i,
    input wire logic [NUM_ZONE-1:0] zone_occ_i,
    input wire logic                cam_fail_i,
    input wire logic                power_fail_i,
    input wire logic [NUM_OUT-1:0]  call_o,
    input wire logic [NUM_ZONE-1:0] zone_hilite_o,
    input wire logic                remote_frame_o
);
    logic [31:0] rfr_cnt_ff;
    logic        rfr_seen_ff;
    logic [31:0] gap_cnt_ff;
    // ====
    // Cycles since last refresh pulse and since last frame
    always_ff @(posedge clk_i)
    begin
        rfr_cnt_ff  <= (rst_i || remote_frame_o) ? 32'h0000_0000 : rfr_cnt_ff + 32'h0000_0001;
        rfr_seen_ff <= !rst_i && (rfr_seen_ff || remote_frame_o);
        gap_cnt_ff  <= (rst_i || frame_i) ? 32'h0000_0000 : gap_cnt_ff + 32'h0000_0001;
    end
    ack_pulse_a:
        assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
        else $error("ack lasted more than one cycle");
    ack_answer_a:
        assert property (@(posedge clk_i) disable iff (rst_i)
            (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i) |=> wb_ack_o)
        else $error("request not answered next cycle");
    ack_spurious_a:
        assert property (@(posedge clk_i) disable iff (rst_i)
            !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    reset_quiet_a:
        assert property (@(posedge clk_i) disable iff (!ce_i)
            rst_i |=> (call_o == '0 && zone_hilite_o == '0 && !wb_ack_o && !remote_frame_o))
        else $error("outputs active after reset edge");
    cam_fail_a:  // camera fail
        assert property (@(posedge clk_i) disable iff (rst_i) cam_fail_i [*4] |=> (call_o == '1))
        else $error("camera fail did not force calls");
    power_fail_a:  // power fail
        assert property (@(posedge clk_i) disable iff (rst_i) power_fail_i [*4] |=> &call_o)
        else $error("power fail did not force calls");
    hilite_a:  // zone outline
        assert property (@(posedge clk_i) disable iff (rst_i)
            frame_i |-> ##2 (zone_hilite_o == $past(zone_occ_i, 2)))
        else $error("highlight does not follow captured occupancy");
    refresh_a:  // refresh spacing
        assert property (@(posedge clk_i) disable iff (rst_i)
            (remote_frame_o && rfr_seen_ff) |-> (rfr_cnt_ff == 32'(REFRESH_CYC - 1)))
        else $error("remote frame spacing wrong");
    frame_lost_a:  // missing frames
        assert property (@(posedge clk_i) disable iff (rst_i)
            (gap_cnt_ff > 32'(FRAME_CYC + 3)) |-> (call_o == '1))
        else $error("lost frames did not force calls");
endmodule : det_call_props

// file: tb/detector_call_delay_extend_test.sv
// Bench for the call block: register access, timing modes, fail-safe.
// Assumes reduced tick, frame-watchdog and refresh counts set below.
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin $display("unexpected at %0t got %h exp %h", $time, g, e); miscompares++; end end
module detector_call_delay_extend_test;
    import det_pkg::*;
    localparam int TK = 4;
    localparam int FP = 10;
    localparam int DL = 6;
    logic clk_i = 0, rst_i = 1, ce_i = 1, frame_i = 0, frame_run = 1;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, cam_fail_i = 0, power_fail_i = 0;
    logic [7:0]  wb_adr_i = 0, zone_occ_i = 0, zone_dir_i = 0, green_req = 0, green, calls;
    logic [7:0]  hilite, rises, c0;
    logic [3:0]  wb_sel_i = 4'hF, fcnt = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o;
    logic        wb_ack_o, remote, ok, exp_on;
    int          miscompares = 0, tests_run = 0, cycles = 0, t;
    detector_call_delay_extend #(.TICK_CYC(TK), .FRAME_CYC(50), .REFRESH_CYC(16)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_i(frame_i), .zone_occ_i(zone_occ_i),
        .zone_dir_i(zone_dir_i), .phase_green_i(green), .cam_fail_i(cam_fail_i),
        .power_fail_i(power_fail_i), .call_o(calls), .zone_hilite_o(hilite),
        .remote_frame_o(remote));
    ctl_model ctl_u (.clk_i(clk_i), .rst_i(rst_i), .call_i(calls), .green_req_i(green_req),
        .phase_green_o(green), .rise_cnt_o(rises));
    always #5 clk_i = ~clk_i;
    // ====
    // Frame strobe every FP cycles; the watchdog sees a stop as a failure
    always @(posedge clk_i)
    begin
        fcnt    <= (rst_i || !frame_run || fcnt == 4'h9) ? 4'h0 : fcnt + 4'h1;
        frame_i <= !rst_i && frame_run && fcnt == 4'h9;
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test
    task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        // Request stands until ack is sampled high at a rising edge
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb_io
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_io(1'b1, a, d, q);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb_io(1'b0, a, 32'h0000_0000, q);
        `CHK(q, e)
    endtask : rd_chk
    task automatic set_occ(input logic [7:0] o, input logic [7:0] d);
        @(posedge clk_i);
        zone_occ_i <= o;
        zone_dir_i <= d;
    endtask : set_occ
    task automatic til(input int k, input logic v, input int lim, output int n);
        n = 0;
        while (calls[k] !== v && n < lim)
        begin
            @(negedge clk_i);
            n++;
        end
        // A wait that runs out is a failure in its own right
        if (calls[k] !== v)
            miscompares++;
    endtask : til
    function automatic logic [31:0] cfgw(timing_mode_t m, zone_func_t f, logic [7:0] dl,
                                         logic [7:0] ex, logic [2:0] z);
        return {5'h00, z, ex, dl, 2'h0, f, 1'h0, m};
    endfunction : cfgw
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(CTRL_OFS, CTRL_RST);
        rd_chk(CFG_BASE + 8'h0C, 32'h0300_0000);
        wr(8'h40, 32'hFFFF_FFFF);
        rd_chk(8'h40, 32'h0000_0000);
        wr(CFG_BASE, 32'hFFFF_FFFF);
        rd_chk(CFG_BASE, CFG_MASK);
        for (int i = 0; i < 8; i++)
            wr(CFG_BASE + 8'(4 * i), cfgw(TM_EXTEND, ZF_PRES, 8'h00, 8'h00, 3'(i % 7)));
        set_occ(8'h25, 8'h00);
        repeat (2 * FP + 4) @(negedge clk_i);
        `CHK(calls, 8'hA5)
        `CHK(hilite, 8'h25)
        rd_chk(STAT_OFS, 32'h0000_25A5);
        set_occ(8'h00, 8'h00);
        til(0, 1'b0, 40, t);
        set_occ(8'h01, 8'h00);
        til(0, 1'b1, 40, t);
        `CHK(t <= FP + 4, 1'b1)
        wr(CFG_BASE, cfgw(TM_EXTEND, ZF_PRES, 8'h00, 8'h03, 3'h0));
        set_occ(8'h00, 8'h00);
        til(0, 1'b0, 80, t);
        `CHK(t >= 3 * TK && t <= 4 * TK + FP + 4, 1'b1)
        wr(CFG_BASE, cfgw(TM_FULL_DLY, ZF_PRES, DL, 8'h00, 3'h0));
        green_req <= 8'h01;
        set_occ(8'h01, 8'h00);
        til(0, 1'b1, 80, t);
        `CHK(t >= (DL - 1) * TK && t <= (DL + 1) * TK + FP + 4, 1'b1)
        wr(CFG_BASE, cfgw(TM_NORM_DLY, ZF_PRES, DL, 8'h00, 3'h0));
        set_occ(8'h00, 8'h00);
        til(0, 1'b0, 40, t);
        set_occ(8'h01, 8'h00);
        repeat (80) @(negedge clk_i);
        `CHK(calls[0], 1'b0)
        wr(CTRL_OFS, 32'h0000_0003);
        til(0, 1'b1, 60, t);
        `CHK(calls[0], 1'b1)
        wr(CTRL_OFS, CTRL_RST);
        wr(CFG_BASE, cfgw(TM_DLY_EXT, ZF_PRES, DL, 8'h08, 3'h0));
        set_occ(8'h00, 8'h00);
        til(0, 1'b0, 80, t);
        set_occ(8'h01, 8'h00);
        til(0, 1'b1, 80, t);
        `CHK(t >= (DL - 1) * TK, 1'b1)
        // Short gap and re-entry, all inside the extend time
        set_occ(8'h00, 8'h00);
        repeat (FP + 2) @(negedge clk_i);
        set_occ(8'h01, 8'h00);
        ok = 1'b1;
        repeat (30)
        begin
            @(negedge clk_i);
            if (calls[0] !== 1'b1) ok = 1'b0;
        end
        `CHK(ok, 1'b1)
        set_occ(8'h00, 8'h00);
        til(0, 1'b0, 120, t);
        `CHK(t >= 8 * TK, 1'b1)
        set_occ(8'h01, 8'h00);
        til(0, 1'b1, 80, t);
        `CHK(t >= (DL - 1) * TK, 1'b1)
        set_occ(8'h00, 8'h00);
        repeat (80) @(negedge clk_i);
        for (int f = 0; f < 8; f++)
        begin
            wr(CFG_BASE, cfgw(TM_EXTEND, zone_func_t'(f / 2), 8'h00, 8'h00, 3'h0));
            c0 = rises;
            exp_on = (f / 2) % 2 == 0 || f % 2 == 1;
            set_occ(8'h01, {8{f % 2 == 1}});
            repeat (40) @(negedge clk_i);
            `CHK(rises - c0, {7'h00, exp_on})
            `CHK(calls[0], exp_on && f < 4)
            set_occ(8'h00, 8'h00);
            repeat (30) @(negedge clk_i);
        end
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk_i);
            if (k == 0) cam_fail_i <= 1'b1;
            if (k == 1) power_fail_i <= 1'b1;
            if (k == 2) wr(CTRL_OFS, 32'h0000_0000);
            if (k == 3) frame_run <= 1'b0;
            repeat (60) @(negedge clk_i);
            `CHK(calls, 8'hFF)
            rd_chk(STAT_OFS, {13'h0000, k == 3, k == 1, k == 0, 16'h00FF});
            @(posedge clk_i);
            cam_fail_i   <= 1'b0;
            power_fail_i <= 1'b0;
            frame_run    <= 1'b1;
            wr(CTRL_OFS, CTRL_RST);
            repeat (2 * FP + 4) @(negedge clk_i);
            `CHK(calls, 8'h00)
        end
        stop_test();
    end
endmodule : detector_call_delay_extend_test
bind detector_call_delay_extend det_call_props #(
    .NUM_OUT(NUM_OUT), .NUM_ZONE(NUM_ZONE), .FRAME_CYC(FRAME_CYC), .REFRESH_CYC(REFRESH_CYC)
) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .frame_i(frame_i), .zone_occ_i(zone_occ_i), .cam_fail_i(cam_fail_i),
    .power_fail_i(power_fail_i), .call_o(call_o), .zone_hilite_o(zone_hilite_o),
    .remote_frame_o(remote_frame_o));
